/* logic/cis_defines.vh */
// Shared constants for the interrupt sequencer: register map, bit positions, cycle counts.
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH
`define CIS_AW 8
`define CIS_OFF_FLAGS 8'h00
`define CIS_OFF_ENABLE 8'h04
`define CIS_OFF_CORECTRL 8'h08
`define CIS_OFF_PROCFLAGS 8'h0c
`define CIS_OFF_STATUS 8'h10
`define CIS_OFF_PCSEEN 8'h14
`define CIS_BIT_GIE 7
`define CIS_BIT_VECTOR_TABLE_SELECT 0
`define CIS_RST_PROCFLAGS 8'h00
`define CIS_RST_CORECTRL 1'b0
`define CIS_ENTRY_NS 16
`define CIS_RET_NS 16
`define CIS_SLEEP_NS 16
`define CIS_JUMP_NS 12
`define CIS_CLK_NS 4
`define CIS_ENTRY_CYC ((`CIS_ENTRY_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_RET_CYC ((`CIS_RET_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_SLEEP_CYC ((`CIS_SLEEP_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_JUMP_CYC ((`CIS_JUMP_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_CNTW 4
`define CIS_RESP_OKAY 2'b00
`define CIS_RESP_SLVERR 2'b10
`define CIS_ST_IDLE 3'b001
`define CIS_ST_ENTRY 3'b010
`define CIS_ST_RET 3'b100
`define CIS_ALU_ADD 2'b00
`define CIS_ALU_SUB 2'b01
`define CIS_ALU_AND 2'b10
`define CIS_ALU_OR 2'b11
`endif

/* logic/cis_sequencer.v */
// Interrupt acceptance and sequencing logic with an AXI4-Lite register slave.
`timescale 1ns/100ps
// Functional notes
// RQ1: Core runs straight on clk, no divider.
// RQ2: Two-operand ALU result written in one cycle.
// RQ3: Take source only if enabled and global enabled.
// RQ4: Reset and every source have own vector.
// RQ5: Lowest vector wins; reset first, then source zero.
// RQ6: Table select moves vectors to boot start.
// RQ7: Boot reset fuse moves reset vector.
// RQ8: Boot lock bits suppress interrupts by program counter.
// RQ9: Acceptance clears global enable.
// RQ10: Software may set global enable for nesting.
// RQ11: Return takes four cycles, pops, sets enable.
// RQ12: Vectoring clears the served event flag.
// RQ13: Writing one to a flag clears it.
// RQ14: Flag stays latched while source disabled.
// RQ15: Latched flags served by priority once enabled.
// RQ16: Condition sources request only while present.
// RQ17: One main instruction runs after return.
// RQ18: Handler software saves the flag register.
// RQ19: Disable instruction blocks same-cycle interrupt.
// RQ20: Instruction after enable runs before interrupt.
// RQ21: Entry takes four cycles pushing program counter.
// RQ22: Multi-cycle instruction completes before service.
// RQ23: Wake from sleep adds four cycles.
// RQ24: Entry push lowers stack pointer by two.
// RQ25: Global enable is flag register bit seven.
// RQ26: Reset clears global enable.
`include "cis_defines.vh"
module cis_sequencer #(
	parameter NSRC = 8,
	parameter IW = 3,
	parameter PCW = 12,
	parameter [31:0] LEVEL_MASK = 32'h00000000,
	parameter [PCW-1:0] BOOT_START = 12'hc00,
	parameter [PCW-1:0] VEC_STEP = 12'h001
) (
	input wire clk,
	input wire reset,
	input wire [`CIS_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`CIS_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [NSRC-1:0] srcIn,
	input wire instrBoundary,
	input wire instrCli,
	input wire instrSei,
	input wire instrReti,
	input wire sleepReady,
	input wire [PCW-1:0] programCounter,
	input wire bootResetFuse,
	input wire appBootLockBit,
	input wire bootSectionLockBit,
	input wire aluGo,
	input wire [1:0] aluOp,
	input wire [7:0] aluA,
	input wire [7:0] aluB,
	output reg busy_q,
	output reg irqTaken_q,
	output reg [PCW-1:0] vectorAddr_q,
	output reg pushActive_q,
	output reg spDecTwo_q,
	output reg pcLoad_q,
	output reg popActive_q,
	output reg spIncTwo_q,
	output reg retDone_q,
	output reg [PCW-1:0] resetVector_q,
	output reg globalEnable_q,
	output reg [7:0] aluResult_q,
	output reg aluWrite_q
);
	localparam [NSRC-1:0] LVL = LEVEL_MASK[NSRC-1:0];
	localparam integer ENTRY_I = `CIS_ENTRY_CYC;
	localparam integer RET_I = `CIS_RET_CYC;
	localparam integer SLEEP_I = `CIS_SLEEP_CYC;
	localparam [`CIS_CNTW-1:0] ENTRY_N = ENTRY_I[`CIS_CNTW-1:0];
	localparam [`CIS_CNTW-1:0] RET_N = RET_I[`CIS_CNTW-1:0];
	localparam [`CIS_CNTW-1:0] SLEEP_N = SLEEP_I[`CIS_CNTW-1:0];
	localparam [7:0] RST_FLAGS = `CIS_RST_PROCFLAGS;
	localparam [`CIS_CNTW-1:0] ONE = 4'h1;

	reg [NSRC-1:0] flag_q;
	reg [NSRC-1:0] enable_q;
	reg vectorTableSelect_q;
	reg [6:0] procFlagsLow_q;
	reg [2:0] state_q;
	reg [`CIS_CNTW-1:0] count_q;
	reg inhibit_q;
	reg [IW-1:0] lastIdx_q;
	reg [PCW-1:0] pcSeen_q;
	reg strapDone_q;
	reg [`CIS_AW-1:0] awAddr_q;
	reg awHave_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg wHave_q;

	reg [NSRC-1:0] pending;
	reg [NSRC-1:0] request;
	reg [NSRC-1:0] hwClear;
	reg [IW-1:0] winIdx;
	reg found;
	reg lockSuppress;
	reg takeAtBoundary;
	reg takeFromSleep;
	reg accept;
	reg [PCW-1:0] vecBase;
	reg [PCW-1:0] vecCalc;
	reg [31:0] readData;
	reg readHit;
	reg writeHit;
	integer i;

	wire wrCommit = awHave_q && wHave_q && !s_axi_bvalid;
	wire wrLane0 = wrCommit && wStrb_q[0];
	wire wrFlags = wrLane0 && awAddr_q == `CIS_OFF_FLAGS;
	wire wrEnable = wrLane0 && awAddr_q == `CIS_OFF_ENABLE;
	wire wrCtrl = wrLane0 && awAddr_q == `CIS_OFF_CORECTRL;
	wire wrProc = wrLane0 && awAddr_q == `CIS_OFF_PROCFLAGS;
	wire inBoot = programCounter >= BOOT_START;
	wire retLast = state_q == `CIS_ST_RET && count_q == ONE;

	always @* begin
		pending = (flag_q & ~LVL) | (srcIn & LVL); // RQ16
		request = pending & enable_q; // RQ3 RQ14
		winIdx = {IW{1'b0}};
		found = 1'b0;
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (request[i]) begin
				winIdx = i[IW-1:0]; // RQ5
				found = 1'b1;
			end
		end
		lockSuppress = (appBootLockBit && !inBoot && vectorTableSelect_q) ||
			(bootSectionLockBit && inBoot && !vectorTableSelect_q); // RQ8
		takeAtBoundary = instrBoundary && !inhibit_q; // RQ17 RQ20 RQ22
		takeFromSleep = sleepReady;
		accept = state_q == `CIS_ST_IDLE && found && globalEnable_q && !instrCli &&
			!lockSuppress && (takeAtBoundary || takeFromSleep); // RQ3 RQ15 RQ19
		hwClear = {NSRC{1'b0}};
		if (accept) begin
			hwClear[winIdx] = !LVL[winIdx]; // RQ12
		end
		vecBase = vectorTableSelect_q ? BOOT_START : {PCW{1'b0}}; // RQ6
		vecCalc = vecBase + ({{(PCW-IW){1'b0}}, winIdx} + {{(PCW-1){1'b0}}, 1'b1}) *
			VEC_STEP; // RQ4
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_q <= {NSRC{1'b0}};
		end else begin
			flag_q <= (flag_q & ~hwClear & ~(wrFlags ? wData_q[NSRC-1:0] : {NSRC{1'b0}})) |
				(srcIn & ~LVL); // RQ13 RQ14
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			enable_q <= {NSRC{1'b0}};
			vectorTableSelect_q <= `CIS_RST_CORECTRL;
			procFlagsLow_q <= 7'h00;
		end else begin
			if (wrEnable) begin
				enable_q <= wData_q[NSRC-1:0];
			end
			if (wrCtrl) begin
				vectorTableSelect_q <= wData_q[`CIS_BIT_VECTOR_TABLE_SELECT];
			end
			if (wrProc) begin
				procFlagsLow_q <= wData_q[6:0];
			end
		end
	end

	// The global enable: hardware acceptance clears it and wins over a software write.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			globalEnable_q <= RST_FLAGS[`CIS_BIT_GIE]; // RQ26
		end else if (accept) begin
			globalEnable_q <= 1'b0; // RQ9
		end else if (instrCli) begin
			globalEnable_q <= 1'b0; // RQ19
		end else if (retLast || instrSei) begin
			globalEnable_q <= 1'b1; // RQ11 RQ20
		end else if (wrProc) begin
			globalEnable_q <= wData_q[`CIS_BIT_GIE]; // RQ10 RQ25
		end
	end

	// Holds off service for exactly one instruction after return or enable.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			inhibit_q <= 1'b0;
		end else if (retLast || (instrSei && !globalEnable_q)) begin
			inhibit_q <= 1'b1; // RQ17 RQ20
		end else if (instrBoundary) begin
			inhibit_q <= 1'b0;
		end
	end

	// Sequencer: entry pushes the return address, return pops it.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= `CIS_ST_IDLE;
			count_q <= {`CIS_CNTW{1'b0}};
			busy_q <= 1'b0;
			irqTaken_q <= 1'b0;
			vectorAddr_q <= {PCW{1'b0}};
			pushActive_q <= 1'b0;
			spDecTwo_q <= 1'b0;
			pcLoad_q <= 1'b0;
			popActive_q <= 1'b0;
			spIncTwo_q <= 1'b0;
			retDone_q <= 1'b0;
			lastIdx_q <= {IW{1'b0}};
			pcSeen_q <= {PCW{1'b0}};
		end else begin
			irqTaken_q <= 1'b0;
			spDecTwo_q <= 1'b0;
			pcLoad_q <= 1'b0;
			spIncTwo_q <= 1'b0;
			retDone_q <= 1'b0;
			case (state_q)
				`CIS_ST_IDLE: begin
					if (accept) begin
						state_q <= `CIS_ST_ENTRY;
						count_q <= takeAtBoundary ? ENTRY_N : ENTRY_N + SLEEP_N; // RQ21 RQ23
						busy_q <= 1'b1;
						irqTaken_q <= 1'b1;
						vectorAddr_q <= vecCalc; // RQ4 RQ5 RQ6
						pushActive_q <= 1'b1;
						spDecTwo_q <= 1'b1; // RQ24
						lastIdx_q <= winIdx;
						pcSeen_q <= programCounter;
					end else if (instrReti) begin
						state_q <= `CIS_ST_RET;
						count_q <= RET_N; // RQ11
						busy_q <= 1'b1;
						popActive_q <= 1'b1;
						spIncTwo_q <= 1'b1; // RQ11
					end
				end
				`CIS_ST_ENTRY: begin
					count_q <= count_q - ONE;
					if (count_q == ONE) begin
						state_q <= `CIS_ST_IDLE;
						busy_q <= 1'b0;
						pushActive_q <= 1'b0;
						pcLoad_q <= 1'b1; // RQ21
					end
				end
				`CIS_ST_RET: begin
					count_q <= count_q - ONE;
					if (count_q == ONE) begin
						state_q <= `CIS_ST_IDLE;
						busy_q <= 1'b0;
						popActive_q <= 1'b0;
						retDone_q <= 1'b1; // RQ11
					end
				end
				default: begin
					state_q <= `CIS_ST_IDLE;
					busy_q <= 1'b0;
					pushActive_q <= 1'b0;
					popActive_q <= 1'b0;
				end
			endcase
		end
	end

	// The fuse is sampled once, after reset is released.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			strapDone_q <= 1'b0;
			resetVector_q <= {PCW{1'b0}};
		end else if (!strapDone_q) begin
			strapDone_q <= 1'b1;
			resetVector_q <= bootResetFuse ? BOOT_START : {PCW{1'b0}}; // RQ7
		end
	end

	// The core logic runs on clk directly; there is no divided clock.
	always @(posedge clk or posedge reset) begin // RQ1
		if (reset) begin
			aluResult_q <= 8'h00;
			aluWrite_q <= 1'b0;
		end else begin
			aluWrite_q <= aluGo; // RQ2
			if (aluGo) begin
				case (aluOp)
					`CIS_ALU_ADD: aluResult_q <= aluA + aluB; // RQ2
					`CIS_ALU_SUB: aluResult_q <= aluA - aluB;
					`CIS_ALU_AND: aluResult_q <= aluA & aluB;
					default: aluResult_q <= aluA | aluB;
				endcase
			end
		end
	end

	// Write side: address and data are taken in either order; the response follows both.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CIS_RESP_OKAY;
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= {`CIS_AW{1'b0}};
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
				awHave_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHave_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wrCommit) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= writeHit ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @* begin
		writeHit = awAddr_q == `CIS_OFF_FLAGS || awAddr_q == `CIS_OFF_ENABLE ||
			awAddr_q == `CIS_OFF_CORECTRL || awAddr_q == `CIS_OFF_PROCFLAGS ||
			awAddr_q == `CIS_OFF_STATUS || awAddr_q == `CIS_OFF_PCSEEN;
		readData = 32'h00000000;
		readHit = 1'b1;
		case (s_axi_araddr)
			`CIS_OFF_FLAGS: readData[NSRC-1:0] = pending;
			`CIS_OFF_ENABLE: readData[NSRC-1:0] = enable_q;
			`CIS_OFF_CORECTRL: readData[`CIS_BIT_VECTOR_TABLE_SELECT] = vectorTableSelect_q;
			`CIS_OFF_PROCFLAGS: readData[7:0] = {globalEnable_q, procFlagsLow_q}; // RQ25
			`CIS_OFF_STATUS: begin
				readData[2:0] = state_q;
				readData[3] = inhibit_q;
				readData[IW+7:8] = lastIdx_q;
			end
			`CIS_OFF_PCSEEN: readData[PCW-1:0] = pcSeen_q;
			default: readHit = 1'b0;
		endcase
	end

	// Read side: one cycle from address handshake to valid data.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CIS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readData;
				s_axi_rresp <= readHit ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // cis_sequencer

/* sim/cis_sequencer_sva.sv */
// Concurrent checks on the interrupt sequencer ports.
`timescale 1ns/100ps
module cis_sequencer_sva (
	input logic clk,
	input logic reset,
	input logic instrCli,
	input logic instrSei,
	input logic aluGo,
	input logic [1:0] aluOp,
	input logic [7:0] aluA,
	input logic [7:0] aluB,
	input logic busy_q,
	input logic irqTaken_q,
	input logic pcLoad_q,
	input logic popActive_q,
	input logic spDecTwo_q,
	input logic spIncTwo_q,
	input logic retDone_q,
	input logic globalEnable_q,
	input logic [7:0] aluResult_q,
	input logic aluWrite_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_take_gie: assert property (irqTaken_q |-> !globalEnable_q && $past(globalEnable_q))
		else $error("take with wrong global enable");
	a_take_push: assert property (irqTaken_q |-> spDecTwo_q && busy_q && !$past(busy_q))
		else $error("entry push missing");
	a_entry_len: assert property (irqTaken_q |-> busy_q[*4] ##[1:5] pcLoad_q)
		else $error("entry length wrong");
	a_ret_len: assert property ($rose(popActive_q) |-> spIncTwo_q ##4
		retDone_q && globalEnable_q && !busy_q) else $error("return sequence wrong");
	a_cli_block: assert property (instrCli |=> !irqTaken_q && !globalEnable_q)
		else $error("take after disable");
	a_ret_gap: assert property (irqTaken_q |-> !$past(retDone_q))
		else $error("take right after return");
	a_sei_gap: assert property (instrSei && !globalEnable_q |=> ##1 !irqTaken_q)
		else $error("take right after enable");
	a_alu_add: assert property (aluGo && aluOp == 2'b00 |=> aluWrite_q &&
		aluResult_q == 8'($past(aluA) + $past(aluB))) else $error("alu add wrong");
endmodule // cis_sequencer_sva

/* sim/cis_pipe_model.sv */
// Pipeline model that completes an instruction each cycle unless busy or stalled.
`timescale 1ns/100ps
module cis_pipe_model (
	input logic busy_q,
	input logic stallIn,
	output logic instrBoundary
);
	// Fetch halts during entry and return; stallIn stretches an instruction.
	assign instrBoundary = !busy_q && !stallIn;
endmodule // cis_pipe_model

/* sim/tb_cpu_interrupt_sequencer.sv */
// Self-checking bench for the interrupt sequencer.
`timescale 1ns/100ps
module tb_cpu_interrupt_sequencer;
	localparam logic [11:0] BS = 12'hc00;
	logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic instrCli, instrSei, instrReti, sleepReady, bootResetFuse, aluGo, stallIn;
	logic appBootLockBit, bootSectionLockBit;
	logic [7:0] s_axi_awaddr, s_axi_araddr, aluA, aluB, srcIn;
	logic [31:0] s_axi_wdata, rd, rnd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] aluOp, rr, br;
	logic [11:0] programCounter;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, instrBoundary;
	wire busy_q, irqTaken_q, pushActive_q, spDecTwo_q, pcLoad_q, popActive_q, spIncTwo_q;
	wire retDone_q, globalEnable_q, aluWrite_q;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [11:0] vectorAddr_q, resetVector_q;
	wire [7:0] aluResult_q;
	int errors, comparisons, n;
	cis_sequencer #(.BOOT_START(BS), .LEVEL_MASK(32'h00000080)) dut_u (.*);
	cis_pipe_model pipe_u (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] alu(input logic [1:0] o, input logic [7:0] a, input logic [7:0] b);
		case (o)
			2'b00: return a + b;
			2'b01: return a - b;
			2'b10: return a & b;
			default: return a | b;
		endcase
	endfunction
	function automatic logic [11:0] vec(input int i, input logic v);
		return (v ? BS : 12'h000) + 12'(i + 1);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				br = s_axi_bresp;
				done = 1'b1;
			end
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		logic done;
		done = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				rd = s_axi_rdata;
				rr = s_axi_rresp;
				done = 1'b1;
			end
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic wt(input logic r);
		int k;
		k = 0;
		while ((r ? retDone_q : irqTaken_q) !== 1'b1 && k < 60) begin
			@(posedge clk);
			k++;
		end
		if (k >= 60) begin
			errors++;
			$display("wrong value at %0t: sequencer event never came", $time);
		end
	endtask
	task automatic quiet(input int m);
		n = 0;
		repeat (m) begin
			@(posedge clk);
			if (irqTaken_q !== 1'b0) n++;
		end
	endtask
	task automatic upto_load();
		n = 0;
		while (pcLoad_q !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic pulse(input logic [7:0] s);
		@(posedge clk);
		srcIn <= s;
		@(posedge clk);
		srcIn <= 8'h00;
	endtask
	task automatic ret();
		repeat (4) @(posedge clk);
		instrReti <= 1'b1;
		@(posedge clk);
		instrReti <= 1'b0;
		wt(1'b1);
		chk(globalEnable_q, 1);
	endtask
	task automatic finish_test();
		if (errors == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		errors++;
		$display("wrong value at %0t: watchdog ran out", $time);
		finish_test();
	end
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, srcIn, instrCli, instrSei, instrReti} = '0;
		{sleepReady, bootResetFuse, appBootLockBit, bootSectionLockBit, aluGo} = '0;
		{aluOp, aluA, aluB, programCounter, stallIn} = '0;
		s_axi_wstrb = 4'hf;
		rnd = 32'h4ebac7b5;
		reset = 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		chk(resetVector_q, 0);
		chk(globalEnable_q, 0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rnd = lfsr(rnd);
			aluGo <= 1'b1;
			aluOp <= i[1:0];
			aluA <= rnd[9:2];
			aluB <= rnd[17:10];
			programCounter <= rnd[29:18];
			stallIn <= rnd[30];
			@(posedge clk);
			aluGo <= 1'b0;
			@(posedge clk);
			chk(aluResult_q, alu(aluOp, aluA, aluB));
		end
		stallIn <= 1'b0;
		axr(8'h0c);
		chk(rd, 0);
		axr(8'h18);
		chk(rr, 2'b10);
		axw(8'h18, 32'hff);
		chk(br, 2'b10);
		pulse(8'h08);
		axr(8'h00);
		chk(rd, 32'h08);
		axw(8'h00, 32'h08);
		axr(8'h00);
		chk(rd, 0);
		axw(8'h04, 32'hff);
		pulse(8'h24);
		axr(8'h00);
		chk(rd, 32'h24);
		@(posedge clk);
		instrSei <= 1'b1;
		@(posedge clk);
		instrSei <= 1'b0;
		wt(1'b0);
		chk(vectorAddr_q, vec(2, 1'b0));
		chk(globalEnable_q, 0);
		axr(8'h00);
		chk(rd, 32'h20);
		axw(8'h08, 32'h01);
		axw(8'h0c, 32'h80);
		wt(1'b0);
		chk(vectorAddr_q, vec(5, 1'b1));
		pulse(8'h01);
		ret();
		n = 0;
		while (irqTaken_q !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk(n, 2);
		chk(vectorAddr_q, vec(0, 1'b1));
		pulse(8'h02);
		ret();
		instrCli <= 1'b1;
		@(posedge clk);
		instrCli <= 1'b0;
		n = 0;
		repeat (12) begin
			@(posedge clk);
			if (irqTaken_q !== 1'b0) n++;
		end
		chk(n, 0);
		chk(globalEnable_q, 0);
		appBootLockBit <= 1'b1;
		programCounter <= 12'h010;
		axw(8'h0c, 32'h85);
		chk(br, 2'b00);
		quiet(8);
		chk(n, 0);
		stallIn <= 1'b1;
		programCounter <= BS;
		quiet(8);
		chk(n, 0);
		stallIn <= 1'b0;
		wt(1'b0);
		chk(pushActive_q, 1);
		chk(vectorAddr_q, vec(1, 1'b1));
		upto_load();
		chk(n, 4);
		chk(pushActive_q, 0);
		axr(8'h14);
		chk(rd, BS);
		appBootLockBit <= 1'b0;
		ret();
		axr(8'h0c);
		chk(rd, 32'h85);
		stallIn <= 1'b1;
		sleepReady <= 1'b1;
		pulse(8'h40);
		wt(1'b0);
		chk(vectorAddr_q, vec(6, 1'b1));
		upto_load();
		chk(n, 8);
		sleepReady <= 1'b0;
		stallIn <= 1'b0;
		ret();
		s_axi_wstrb <= 4'he;
		axw(8'h04, 32'h00);
		s_axi_wstrb <= 4'hf;
		axr(8'h04);
		chk(rd, 32'hff);
		axw(8'h04, 32'h7f);
		pulse(8'h80);
		axr(8'h00);
		chk(rd, 0);
		axw(8'h04, 32'hff);
		quiet(8);
		chk(n, 0);
		srcIn <= 8'h80;
		wt(1'b0);
		srcIn <= 8'h00;
		chk(vectorAddr_q, vec(7, 1'b1));
		bootResetFuse <= 1'b1;
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		chk(resetVector_q, BS);
		finish_test();
	end
endmodule // tb_cpu_interrupt_sequencer
bind cis_sequencer cis_sequencer_sva chk_u (.*);
